/* qsa_map.vh */
// Purpose: Register map, fields and timing counts of the sample accumulator
// Assumes: 32-bit AXI4-Lite data, one aligned word per register
// Notes:   Definitions only
`ifndef QSA_MAP_VH
`define QSA_MAP_VH

// Register byte offsets
`define QSA_OFF_SAMPLE_PERIOD   12'h508
`define QSA_OFF_MOTION_SAMPLE   12'h50C
`define QSA_OFF_REPORT_INTERVAL 12'h510
`define QSA_OFF_POSITION_TOTAL  12'h514
`define QSA_OFF_COUNT_SNAPSHOT  12'h518
`define QSA_OFF_DOUBLE_COUNTER  12'h544
`define QSA_OFF_CONTROL         12'h600
`define QSA_OFF_TASKS           12'h604
`define QSA_OFF_EVENT_STATUS    12'h608
`define QSA_OFF_EVENT_MASK      12'h60C

// Field widths and reset values
`define QSA_PERIOD_W            4
`define QSA_INTERVAL_W          4
`define QSA_EVENT_W             4
`define QSA_PERIOD_RST          4'h0
`define QSA_INTERVAL_RST        4'h0

// Control, task and event bit positions
`define QSA_CTRL_RUN            0
`define QSA_TASK_CLR_BOTH       0
`define QSA_TASK_CLR_COUNT      1
`define QSA_EV_SAMPLE           0
`define QSA_EV_REPORT           1
`define QSA_EV_OVERFLOW         2
`define QSA_EV_DOUBLE           3

// Motion sample codes
`define QSA_CODE_ZERO           2'h0
`define QSA_CODE_PLUS           2'h1
`define QSA_CODE_DOUBLE         2'h2
`define QSA_CODE_MINUS          2'h3

// Timing: base sample period and clock rate
`define QSA_SAMPLE_PERIOD_US    128
`define QSA_CORE_CLK_MHZ        40
`define QSA_SAMPLE_BASE_CYCLES  (`QSA_SAMPLE_PERIOD_US * `QSA_CORE_CLK_MHZ)

// Samples per report for each interval code
`define QSA_RPT_0               9'h00A
`define QSA_RPT_1               9'h028
`define QSA_RPT_2               9'h050
`define QSA_RPT_3               9'h078
`define QSA_RPT_4               9'h0A0
`define QSA_RPT_5               9'h0C8
`define QSA_RPT_6               9'h0F0
`define QSA_RPT_7               9'h118
`define QSA_RPT_8               9'h001

// Position total limits and double counter ceiling
`define QSA_ACC_MAX             1023
`define QSA_ACC_MIN             (-1024)
`define QSA_DBL_MAX             4'hF

`endif

/* qsa_sampler.v */
// Purpose: Sample period divider and two-phase step decoder
// Assumes: Phase inputs already synchronous to clk
// Notes:   Period is base << select, select 0 is the base period
`timescale 1ns/1ps
`include "qsa_map.vh"
module qsa_sampler #(
    parameter BASE_CYCLES = `QSA_SAMPLE_BASE_CYCLES
) (
    input wire clk,
    input wire rst,
    input wire run,
    input wire [`QSA_PERIOD_W-1:0] period_sel,
    input wire phase_a,
    input wire phase_b,
    output reg [1:0] sample_code_r,
    output reg sample_stb_r
);
    localparam [31:0] BASE_W = BASE_CYCLES;

    reg [31:0] div_cnt_r;
    reg [1:0] prev_ab_r;
    wire [31:0] limit = BASE_W << period_sel;
    wire tick = run && (div_cnt_r >= limit - 32'h1);
    wire [1:0] ab = {phase_a, phase_b};
    reg [1:0] code_nxt;

    // Gray order 00-01-11-10 is forward; both bits moving is a double step
    always @* begin
        case ({prev_ab_r, ab})
            4'h1, 4'h7, 4'hE, 4'h8: code_nxt = `QSA_CODE_PLUS;
            4'h2, 4'hB, 4'hD, 4'h4: code_nxt = `QSA_CODE_MINUS;
            4'h3, 4'hC, 4'h6, 4'h9: code_nxt = `QSA_CODE_DOUBLE;
            default: code_nxt = `QSA_CODE_ZERO;
        endcase
    end

    // Divider restarts while stopped so the first sample is one period in
    always @(posedge clk) begin
        if (rst) begin
            div_cnt_r <= 32'h0;
            prev_ab_r <= 2'h0;
            sample_code_r <= `QSA_CODE_ZERO;
            sample_stb_r <= 1'b0;
        end else begin
            sample_stb_r <= tick;
            if (!run) begin
                div_cnt_r <= 32'h0;
                prev_ab_r <= ab;
            end else if (tick) begin
                div_cnt_r <= 32'h0;
                prev_ab_r <= ab;
                sample_code_r <= code_nxt;
            end else begin
                div_cnt_r <= div_cnt_r + 32'h1;
            end
        end
    end
endmodule

/* qsa_accum.v */
// Purpose: Position total, snapshot and double transition counter
// Assumes: One sample strobe at most per cycle
// Notes:   A sample arriving with a clear is added onto the cleared value
`timescale 1ns/1ps
`include "qsa_map.vh"
module qsa_accum #(
    parameter integer ACC_MAX = `QSA_ACC_MAX,
    parameter integer ACC_MIN = `QSA_ACC_MIN,
    parameter [3:0] DBL_MAX = `QSA_DBL_MAX
) (
    input wire clk,
    input wire rst,
    input wire sample_stb,
    input wire [1:0] sample_code,
    input wire clr_both,
    input wire clr_count,
    output reg [31:0] acc_r,
    output reg [31:0] snap_r,
    output reg [3:0] dbl_r,
    output reg ovf_r
);
    localparam signed [32:0] MAX_S = ACC_MAX;
    localparam signed [32:0] MIN_S = ACC_MIN;

    wire clr_acc = clr_both | clr_count;
    wire [31:0] acc_base = clr_acc ? 32'h0 : acc_r;
    wire [3:0] dbl_base = clr_both ? 4'h0 : dbl_r;
    wire is_dbl = sample_code == `QSA_CODE_DOUBLE;
    wire signed [32:0] step = {{31{sample_code[1]}}, sample_code};
    wire signed [32:0] sum = $signed({acc_base[31], acc_base}) + step;
    wire out_of_range = (sum > MAX_S) || (sum < MIN_S);

    always @(posedge clk) begin
        if (rst) begin
            acc_r <= 32'h0;
            snap_r <= 32'h0;
            dbl_r <= 4'h0;
            ovf_r <= 1'b0;
        end else begin
            ovf_r <= 1'b0;
            if (clr_acc)
                snap_r <= acc_r;
            acc_r <= acc_base;
            dbl_r <= dbl_base;
            if (sample_stb) begin
                if (is_dbl) begin
                    // Double steps are counted, never added
                    if (dbl_base == DBL_MAX)
                        ovf_r <= 1'b1;
                    else
                        dbl_r <= dbl_base + 4'h1;
                end else if (out_of_range) begin
                    ovf_r <= 1'b1;
                end else begin
                    acc_r <= sum[31:0];
                end
            end
        end
    end
endmodule

/* qsa_top.v */
// Purpose: Quadrature sample accumulator with AXI4-Lite register slave
// Assumes: Phase inputs synchronous to CORE_CLK at 40 MHz
// Notes:   Events are sticky status bits, write one to clear
//          IRQ is registered from the same next status as the bits
//
// Summary of operation
// - one sample per period, 0 means 128us
// - no window events before window samples counted
// - window time is period times samples
// - interval codes map 10..280 samples, 8 one
// - valid samples are added to position total
// - double transition samples are never added
// - position total read-only, 32-bit two's complement
// - overflowing sample dropped, overflow event raised
// - either clear task zeroes the position total
// - window done and total nonzero gives report
// - window done and doubles nonzero gives double
// - snapshot taken before the clear
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
`include "qsa_map.vh"
module qsa_top #(
    parameter SAMPLE_BASE_CYCLES = `QSA_SAMPLE_BASE_CYCLES,
    parameter ADDR_W = 12
) (
    // Clock, reset and encoder phases
    input wire CORE_CLK,
    input wire RST,
    input wire PHASE_A,
    input wire PHASE_B,

    // Write address channel
    input wire [ADDR_W-1:0] S_AXI_AWADDR,
    input wire S_AXI_AWVALID,
    output wire S_AXI_AWREADY,

    // Write data channel
    input wire [31:0] S_AXI_WDATA,
    input wire [3:0] S_AXI_WSTRB,
    input wire S_AXI_WVALID,
    output wire S_AXI_WREADY,

    // Write response channel
    output reg [1:0] S_AXI_BRESP,
    output reg S_AXI_BVALID,
    input wire S_AXI_BREADY,

    // Read address channel
    input wire [ADDR_W-1:0] S_AXI_ARADDR,
    input wire S_AXI_ARVALID,
    output wire S_AXI_ARREADY,

    // Read data channel
    output reg [31:0] S_AXI_RDATA,
    output reg [1:0] S_AXI_RRESP,
    output reg S_AXI_RVALID,
    input wire S_AXI_RREADY,

    // Level interrupt, high while an unmasked event is pending
    output reg IRQ
);
    // Response codes; SLVERR marks an unmapped word
    localparam [1:0] RESP_OKAY = 2'h0;
    localparam [1:0] RESP_SLVERR = 2'h2;

    // Samples per report window for an interval code
    function [8:0] samples_per_report;
        input [`QSA_INTERVAL_W-1:0] code;
        begin
            case (code)
                4'h0: samples_per_report = `QSA_RPT_0;
                4'h1: samples_per_report = `QSA_RPT_1;
                4'h2: samples_per_report = `QSA_RPT_2;
                4'h3: samples_per_report = `QSA_RPT_3;
                4'h4: samples_per_report = `QSA_RPT_4;
                4'h5: samples_per_report = `QSA_RPT_5;
                4'h6: samples_per_report = `QSA_RPT_6;
                4'h7: samples_per_report = `QSA_RPT_7;
                4'h8: samples_per_report = `QSA_RPT_8;
                default: samples_per_report = `QSA_RPT_0;
            endcase
        end
    endfunction

    // Address decode shared by both channels
    function mapped;
        input [ADDR_W-1:0] a;
        begin
            case (a)
                `QSA_OFF_SAMPLE_PERIOD,
                `QSA_OFF_MOTION_SAMPLE,
                `QSA_OFF_REPORT_INTERVAL,
                `QSA_OFF_POSITION_TOTAL,
                `QSA_OFF_COUNT_SNAPSHOT,
                `QSA_OFF_DOUBLE_COUNTER,
                `QSA_OFF_CONTROL,
                `QSA_OFF_TASKS,
                `QSA_OFF_EVENT_STATUS,
                `QSA_OFF_EVENT_MASK: mapped = 1'b1;
                default: mapped = 1'b0;
            endcase
        end
    endfunction

    // Software registers
    reg [`QSA_PERIOD_W-1:0] period_r;
    reg [`QSA_INTERVAL_W-1:0] interval_r;
    reg run_r;
    reg [`QSA_EVENT_W-1:0] status_r;
    reg [`QSA_EVENT_W-1:0] mask_r;

    // Write channel holding state
    reg aw_got_r;
    reg w_got_r;
    reg [ADDR_W-1:0] waddr_r;
    reg [31:0] wdata_r;
    reg [3:0] wstrb_r;

    // Window state
    reg [8:0] win_cnt_r;
    reg win_done_r;

    // Links between sampler, accumulator and register file
    wire [1:0] sample_code;
    wire sample_stb;
    wire [31:0] acc;
    wire [31:0] snap;
    wire [3:0] dbl;
    wire ovf;

    // Each half is taken once; both block while a response waits
    assign S_AXI_AWREADY = !aw_got_r && !S_AXI_BVALID;
    assign S_AXI_WREADY = !w_got_r && !S_AXI_BVALID;
    assign S_AXI_ARREADY = !S_AXI_RVALID;

    // Apply stage; task bits act only for the one apply cycle
    wire do_write = aw_got_r && w_got_r && !S_AXI_BVALID;
    wire lane0 = wstrb_r[0];
    wire wr_hit_tasks = do_write && lane0 && (waddr_r == `QSA_OFF_TASKS);
    wire clr_both = wr_hit_tasks && wdata_r[`QSA_TASK_CLR_BOTH];
    wire clr_count = wr_hit_tasks && wdata_r[`QSA_TASK_CLR_COUNT];
    wire [8:0] win_len = samples_per_report(interval_r);
    wire [31:0] sample_word = {{30{sample_code[1] & sample_code[0]}}, sample_code};

    // Sample timing and step decode
    qsa_sampler #(
        .BASE_CYCLES(SAMPLE_BASE_CYCLES)
    ) u_sampler (
        .clk(CORE_CLK),
        .rst(RST),
        .run(run_r),
        .period_sel(period_r),
        .phase_a(PHASE_A),
        .phase_b(PHASE_B),
        .sample_code_r(sample_code),
        .sample_stb_r(sample_stb)
    );

    // Total, snapshot and double counter
    qsa_accum u_accum (
        .clk(CORE_CLK),
        .rst(RST),
        .sample_stb(sample_stb),
        .sample_code(sample_code),
        .clr_both(clr_both),
        .clr_count(clr_count),
        .acc_r(acc),
        .snap_r(snap),
        .dbl_r(dbl),
        .ovf_r(ovf)
    );

    // Write address and data are taken in either order, then applied once
    always @(posedge CORE_CLK) begin
        if (RST) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            waddr_r <= {ADDR_W{1'b0}};
            wdata_r <= 32'h0;
            wstrb_r <= 4'h0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= RESP_OKAY;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_got_r <= 1'b1;
                waddr_r <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_got_r <= 1'b1;
                wdata_r <= S_AXI_WDATA;
                wstrb_r <= S_AXI_WSTRB;
            end
            // Response code is fixed at apply time and held with BVALID
            if (do_write) begin
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= mapped(waddr_r) ? RESP_OKAY : RESP_SLVERR;
            end else if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    // Writable fields; read-only words silently keep their value
    always @(posedge CORE_CLK) begin
        if (RST) begin
            period_r <= `QSA_PERIOD_RST;
            interval_r <= `QSA_INTERVAL_RST;
            run_r <= 1'b0;
            mask_r <= {`QSA_EVENT_W{1'b0}};
        end else if (do_write && lane0) begin
            // Only lane 0 matters; every field sits in the low bits
            case (waddr_r)
                `QSA_OFF_SAMPLE_PERIOD: period_r <= wdata_r[`QSA_PERIOD_W-1:0];
                `QSA_OFF_REPORT_INTERVAL: interval_r <= wdata_r[`QSA_INTERVAL_W-1:0];
                `QSA_OFF_CONTROL: run_r <= wdata_r[`QSA_CTRL_RUN];
                `QSA_OFF_EVENT_MASK: mask_r <= wdata_r[`QSA_EVENT_W-1:0];
                default: ;
            endcase
        end
    end

    // Window counts samples; completion is judged after the last one lands
    always @(posedge CORE_CLK) begin
        if (RST) begin
            win_cnt_r <= 9'h0;
            win_done_r <= 1'b0;
        end else begin
            win_done_r <= 1'b0;
            // Stopping restarts the window; clear tasks do not
            if (!run_r) begin
                win_cnt_r <= 9'h0;
            end else if (sample_stb) begin
                if (win_cnt_r + 9'h1 >= win_len) begin
                    win_cnt_r <= 9'h0;
                    win_done_r <= 1'b1;
                end else begin
                    win_cnt_r <= win_cnt_r + 9'h1;
                end
            end
        end
    end

    // Sticky events: a new event wins over a same-cycle write-one clear
    wire [`QSA_EVENT_W-1:0] ev_now;
    wire [`QSA_EVENT_W-1:0] w1c;
    assign ev_now[`QSA_EV_SAMPLE] = sample_stb;
    assign ev_now[`QSA_EV_REPORT] = win_done_r && (acc != 32'h0);
    assign ev_now[`QSA_EV_OVERFLOW] = ovf;
    assign ev_now[`QSA_EV_DOUBLE] = win_done_r && (dbl != 4'h0);
    assign w1c = (do_write && lane0 && waddr_r == `QSA_OFF_EVENT_STATUS) ?
                 wdata_r[`QSA_EVENT_W-1:0] : {`QSA_EVENT_W{1'b0}};

    // Next status: set wins over a same-cycle write-one clear
    wire [`QSA_EVENT_W-1:0] status_nxt = (status_r & ~w1c) | ev_now;

    // Sticky status bits
    always @(posedge CORE_CLK) begin
        if (RST) begin
            status_r <= {`QSA_EVENT_W{1'b0}};
        end else begin
            status_r <= status_nxt;
        end
    end

    // Interrupt is registered from the same next status, so it never lags
    always @(posedge CORE_CLK) begin
        if (RST) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(status_nxt & mask_r);
        end
    end

    // Read data mux, one cycle after the address is taken
    reg [31:0] rdata_nxt;
    always @* begin
        rdata_nxt = 32'h0;
        case (S_AXI_ARADDR)
            `QSA_OFF_SAMPLE_PERIOD: rdata_nxt[`QSA_PERIOD_W-1:0] = period_r;
            `QSA_OFF_MOTION_SAMPLE: rdata_nxt = sample_word;
            `QSA_OFF_REPORT_INTERVAL: rdata_nxt[`QSA_INTERVAL_W-1:0] = interval_r;
            `QSA_OFF_POSITION_TOTAL: rdata_nxt = acc;
            `QSA_OFF_COUNT_SNAPSHOT: rdata_nxt = snap;
            `QSA_OFF_DOUBLE_COUNTER: rdata_nxt[3:0] = dbl;
            `QSA_OFF_CONTROL: rdata_nxt[`QSA_CTRL_RUN] = run_r;
            `QSA_OFF_EVENT_STATUS: rdata_nxt[`QSA_EVENT_W-1:0] = status_r;
            `QSA_OFF_EVENT_MASK: rdata_nxt[`QSA_EVENT_W-1:0] = mask_r;
            default: rdata_nxt = 32'h0; // Task word reads as zero
        endcase
    end

    // Captured at the take so the data stands unchanged with RVALID
    always @(posedge CORE_CLK) begin
        if (RST) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h0;
            S_AXI_RRESP <= RESP_OKAY;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA <= rdata_nxt;
            S_AXI_RRESP <= mapped(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
        end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
        end
    end
endmodule

/* qsa_top_chk.sv */
// Purpose: Bus and register-value checks on the accumulator top ports
// Assumes: Single clock, synchronous active-high reset
// Notes:   Bound to every qsa_top instance
`timescale 1ns/1ps
module qsa_top_chk #(
    parameter ADDR_W = 12
) (
    input wire CORE_CLK,
    input wire RST,
    input wire [ADDR_W-1:0] S_AXI_ARADDR,
    input wire S_AXI_ARVALID,
    input wire S_AXI_ARREADY,
    input wire [31:0] S_AXI_RDATA,
    input wire [1:0] S_AXI_RRESP,
    input wire S_AXI_RVALID,
    input wire S_AXI_RREADY,
    input wire S_AXI_AWREADY,
    input wire S_AXI_WREADY,
    input wire [1:0] S_AXI_BRESP,
    input wire S_AXI_BVALID,
    input wire S_AXI_BREADY,
    input wire IRQ
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    // Read request taken, and whether it hits a register
    wire tk = S_AXI_ARVALID && S_AXI_ARREADY;
    wire hit = S_AXI_ARADDR inside {12'h508, 12'h50C, 12'h510, 12'h514, 12'h518,
        12'h544, 12'h600, 12'h604, 12'h608, 12'h60C};
    a_bresp_hold:
        assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
        else $error("write response dropped early");
    a_rdata_hold:
        assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
        else $error("read data dropped early");
    a_read_answer:
        assert property (tk |=> S_AXI_RVALID) else $error("read not answered");
    a_ar_blocked:
        assert property (S_AXI_RVALID |-> !S_AXI_ARREADY) else $error("second read taken");
    a_aw_blocked:
        assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
        else $error("write taken during response");
    a_bad_addr:
        assert property (tk && !hit |=> S_AXI_RRESP == 2'h2 && S_AXI_RDATA == 32'h0)
        else $error("unmapped read not refused");
    a_total_range:
        assert property (tk && S_AXI_ARADDR == 12'h514 |=> $signed(S_AXI_RDATA) >= -1024
            && $signed(S_AXI_RDATA) <= 1023) else $error("total out of range");
    a_sample_code:
        assert property (tk && S_AXI_ARADDR == 12'h50C |=> S_AXI_RDATA inside
            {32'h0, 32'h1, 32'h2, 32'hFFFFFFFF}) else $error("bad sample code");
    a_dbl_limit:
        assert property (tk && S_AXI_ARADDR == 12'h544 |=> S_AXI_RDATA <= 32'hF)
        else $error("double count too large");
    // Main scenarios reached
    c_bad_read: cover property (tk && !hit);
    c_irq_rise: cover property ($rose(IRQ));
    c_total_read: cover property (tk && S_AXI_ARADDR == 12'h514);
endmodule

bind qsa_top qsa_top_chk #(.ADDR_W(ADDR_W)) u_chk (.CORE_CLK(CORE_CLK), .RST(RST),
    .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
    .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP),
    .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
    .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WREADY(S_AXI_WREADY),
    .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID),
    .S_AXI_BREADY(S_AXI_BREADY), .IRQ(IRQ));

/* qsa_enc_model.sv */
// Purpose: Two-phase encoder model
// Assumes: Moves requested no closer than one sample period
// Notes:   Phase B leads phase A on forward moves
`timescale 1ns/1ps
module qsa_enc_model (
    input wire clk,
    input wire [1:0] kind,
    output logic pa,
    output logic pb
);
    logic [1:0] pos = 2'h0;
    // Kind 1 forward, 2 back, 3 skips a state
    always @(posedge clk) begin
        if (kind == 2'h1) pos <= pos + 2'h1;
        if (kind == 2'h2) pos <= pos - 2'h1;
        if (kind == 2'h3) pos <= pos + 2'h2; // Illegal jump, seen as double
    end
    // Gray order 00, 01, 11, 10 on {pa, pb}, the sampler's forward order
    assign pa = pos[1];
    assign pb = pos[1] ^ pos[0];
endmodule

/* tb_quadrature_sample_accumulator.sv */
// Purpose: Self-checking bench for the sample accumulator
// Assumes: Base sample period shortened to 8 cycles
// Notes:   Random forward/back moves from a fixed xorshift seed
`timescale 1ns/1ps
`include "qsa_map.vh"
module tb_quadrature_sample_accumulator;
    localparam int PER = 8;
    localparam int LIMIT = 40000;
    logic clk, rst, awv, wv, bready, arv, rready;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, d, seed, exp_tot;
    logic [3:0] wstrb, strb;
    logic [1:0] kind, r;
    wire pa, pb, awready, wready, bvalid, arready, rvalid, irq;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    int err_total, cmp_count, cyc, t0, el;
    qsa_top #(.SAMPLE_BASE_CYCLES(PER)) DUT (.CORE_CLK(clk), .RST(rst), .PHASE_A(pa),
        .PHASE_B(pb), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wv), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready), .IRQ(irq));
    qsa_enc_model enc (.clk(clk), .kind(kind), .pa(pa), .pb(pb));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            err_total++;
            $display("mismatch at %0t: timeout", $time);
            results;
        end
    end
    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Samples per window for an interval code
    function int rpt(input int c);
        case (c)
            0: return `QSA_RPT_0;
            1: return `QSA_RPT_1;
            2: return `QSA_RPT_2;
            3: return `QSA_RPT_3;
            4: return `QSA_RPT_4;
            5: return `QSA_RPT_5;
            6: return `QSA_RPT_6;
            7: return `QSA_RPT_7;
            default: return `QSA_RPT_8;
        endcase
    endfunction
    task chk(input [31:0] got, input [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task chk_flag(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask
    // Ready sampled before the edge, release just after it
    task wr(input [11:0] a, input [31:0] v);
        logic at, wt, bt;
        awaddr <= a;
        wdata <= v;
        wstrb <= strb;
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= 1'b1;
        bt = 1'b0;
        while (!bt) begin
            @(negedge clk);
            at = awv && awready;
            wt = wv && wready;
            bt = bvalid;
            r = bresp;
            @(posedge clk);
            if (at) awv <= 1'b0;
            if (wt) wv <= 1'b0;
        end
        bready <= 1'b0;
        @(posedge clk);
    endtask
    task rd(input [11:0] a);
        logic at, dn;
        araddr <= a;
        arv <= 1'b1;
        rready <= 1'b1;
        dn = 1'b0;
        while (!dn) begin
            @(negedge clk);
            at = arv && arready;
            dn = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (at) arv <= 1'b0;
        end
        rready <= 1'b0;
        @(posedge clk);
    endtask
    task rdchk(input [11:0] a, input [31:0] exp);
        rd(a);
        chk(d, exp);
        chk({30'h0, r}, 32'h0);
    endtask
    // One move per sample period, then let the total settle
    task mv(input [1:0] k, input int n);
        repeat (n) begin
            kind <= k;
            @(posedge clk);
            kind <= 2'h0;
            repeat (PER - 1) @(posedge clk);
        end
        repeat (4 * PER) @(posedge clk);
    endtask
    task results;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        {rst, awv, wv, bready, arv, rready, awaddr, araddr, wdata, wstrb, kind} = {1'b1, 67'h0};
        strb = 4'hF;
        seed = 32'h7E1B;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        // Reset values, unmapped and read-only places
        rdchk(12'h508, 32'h0);
        rdchk(12'h510, 32'h0);
        rdchk(12'h518, 32'h0);
        rd(12'h700);
        chk({30'h0, r}, 32'h2);
        wr(12'h700, 32'h1);
        chk({30'h0, r}, 32'h2);
        wr(12'h514, 32'h55);
        chk({30'h0, r}, 32'h0);
        rdchk(12'h514, 32'h0);
        strb = 4'h0;
        wr(12'h510, 32'h5);
        strb = 4'hF;
        rdchk(12'h510, 32'h0);
        $display("test reset_map done");
        // Steps, doubles and random motion
        wr(12'h600, 32'h1);
        mv(2'h1, 5);
        rdchk(12'h514, 32'h5);
        mv(2'h2, 2);
        rdchk(12'h50C, 32'h0);
        mv(2'h3, 2);
        rdchk(12'h514, 32'h3);
        rdchk(12'h544, 32'h2);
        exp_tot = 32'h3;
        repeat (20) begin
            d = xs();
            mv(d[0] ? 2'h1 : 2'h2, 1);
            exp_tot = d[0] ? exp_tot + 1 : exp_tot - 1;
        end
        rdchk(12'h514, exp_tot);
        $display("test motion done");
        // Clear tasks with snapshot
        wr(12'h604, 32'h2);
        rdchk(12'h518, exp_tot);
        rdchk(12'h514, 32'h0);
        rdchk(12'h544, 32'h2);
        mv(2'h1, 2);
        wr(12'h604, 32'h1);
        rdchk(12'h518, 32'h2);
        rdchk(12'h514, 32'h0);
        rdchk(12'h544, 32'h0);
        mv(2'h1, 2);
        $display("test clear done");
        // Window length per interval code, total held nonzero
        for (int c = 0; c < 9; c++) begin
            wr(12'h600, 32'h0);
            wr(12'h510, c);
            wr(12'h608, 32'hF);
            wr(12'h600, 32'h1);
            t0 = cyc;
            d = 32'h0;
            while (!d[1]) rd(12'h608);
            el = cyc - t0;
            chk_flag(el >= rpt(c) * PER - 2 && el <= rpt(c) * PER + 12, 1'b1);
        end
        mv(2'h3, 1);
        wr(12'h608, 32'hF);
        repeat (3 * PER) @(posedge clk);
        rd(12'h608);
        chk({29'h0, d[3:1]}, 32'h5);
        wr(12'h604, 32'h1);
        wr(12'h608, 32'hF);
        repeat (3 * PER) @(posedge clk);
        rdchk(12'h608, 32'h1);
        $display("test window done");
        // Overflow, underflow and the masked interrupt
        wr(12'h60C, 32'h4);
        mv(2'h1, 1030);
        rdchk(12'h514, 32'd1023);
        chk_flag(irq, 1'b1);
        wr(12'h608, 32'h4);
        repeat (3) @(posedge clk);
        chk_flag(irq, 1'b0);
        wr(12'h604, 32'h1);
        mv(2'h2, 1030);
        rdchk(12'h514, 32'hFFFFFC00);
        chk_flag(irq, 1'b1);
        wr(12'h60C, 32'h0);
        repeat (3) @(posedge clk);
        chk_flag(irq, 1'b0);
        $display("test overflow done");
        results;
    end
endmodule
